// File: src/asa_pkg.sv
/*
 Shared definitions of the add, AND and shift datapath: register
 offsets, flags, opcodes, codes, states and the state record.
 Assumes a 32-bit APB register bus with byte addresses.
*/
package asa_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_ACC_FIRST = 8'h00;
    localparam logic [7:0] OFS_ACC_SECOND = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_COMMAND = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h14;
    localparam logic [7:0] OFS_MEM_DATA = 8'h18;

    // Command word fields
    localparam int CMD_OPC_LSB = 0;
    localparam int CMD_OPR_LSB = 8;
    localparam int CMD_UNMASK_BIT = 24;

    // Status word fields
    localparam int STA_BUSY_BIT = 0;
    localparam int STA_BAD_BIT = 1;
    localparam int STA_IRQ_BIT = 2;

    // Reset and fixed values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'hd0;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [7:0] UNMASK_AND = 8'hef;
    localparam logic [7:0] DIRECT_PAGE = 8'h00;

    // Opcodes per addressing mode
    localparam logic [7:0] OPC_ADS_I = 8'hcb;
    localparam logic [7:0] OPC_ADS_D = 8'hdb;
    localparam logic [7:0] OPC_ADS_E = 8'hfb;
    localparam logic [7:0] OPC_ADS_X = 8'heb;
    localparam logic [7:0] OPC_ADW_I = 8'hc3;
    localparam logic [7:0] OPC_ADW_D = 8'hd3;
    localparam logic [7:0] OPC_ADW_E = 8'hf3;
    localparam logic [7:0] OPC_ADW_X = 8'he3;
    localparam logic [7:0] OPC_ANF_I = 8'h84;
    localparam logic [7:0] OPC_ANF_D = 8'h94;
    localparam logic [7:0] OPC_ANF_E = 8'hb4;
    localparam logic [7:0] OPC_ANF_X = 8'ha4;
    localparam logic [7:0] OPC_ANS_I = 8'hc4;
    localparam logic [7:0] OPC_ANS_D = 8'hd4;
    localparam logic [7:0] OPC_ANS_E = 8'hf4;
    localparam logic [7:0] OPC_ANS_X = 8'he4;
    localparam logic [7:0] OPC_ANC_I = 8'h10;
    localparam logic [7:0] OPC_SHL_E = 8'h78;
    localparam logic [7:0] OPC_SHL_X = 8'h68;

    // Condition flags, most significant bit first
    typedef struct packed {
        logic s;
        logic x;
        logic h;
        logic i;
        logic n;
        logic z;
        logic v;
        logic c;
    } asa_flags_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_ADD_SECOND = 3'h1,
        OP_ADD_DOUBLE = 3'h2,
        OP_AND_FIRST = 3'h3,
        OP_AND_SECOND = 3'h4,
        OP_AND_FLAGS = 3'h5,
        OP_SHIFT_MEM = 3'h6
    } asa_op_t;

    typedef enum logic [1:0] {
        MODE_I = 2'h0,
        MODE_D = 2'h1,
        MODE_E = 2'h2,
        MODE_X = 2'h3
    } asa_mode_t;

    // Gray codes along idle, read, capture, capture low, execute
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_GET_HI = 3'b011,
        ST_GET_LO = 3'b010,
        ST_EXEC = 3'b110
    } asa_fsm_t;

    typedef struct packed {
        logic valid;
        asa_op_t op;
        asa_mode_t mode;
    } asa_decode_t;

    typedef struct packed {
        asa_fsm_t fsm;
        logic [7:0] acc_a;
        logic [7:0] acc_b;
        asa_flags_t flags;
        asa_op_t op;
        asa_mode_t mode;
        logic [15:0] operand;
        logic [15:0] mem_opnd;
        logic [31:0] cmd_last;
        logic bad_opcode;
        logic irq_hold;
        logic irq_allowed;
        logic [15:0] sw_addr;
        logic mem_pend;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } asa_state_t;

endpackage

// File: src/asa_mem.sv
/*
 Byte-wide operand memory with one port and a registered read.
 Assumes one access per cycle; read data appear one edge after en.
*/
`timescale 1ns/1ns
module asa_mem #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // Access port
    input logic en,
    input logic we,
    input logic [ADDR_W-1:0] addr,
    input logic [7:0] wdata,
    output logic [7:0] rdata
);

    logic [7:0] mem [0:(1<<ADDR_W)-1];

    // Array has no reset; contents are whatever software loads or a shift writes back
    always_ff @(posedge pclk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
    end

    // Read register keeps its old value when the port is idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= 8'h00;
        end else if (en && !we) begin
            rdata <= mem[addr];
        end
    end

endmodule

// File: src/asa_alu.sv
/*
 Combinational result and flag logic for the add, AND and shift group.
 Assumes the operand is already fetched: low byte for 8-bit work,
 full word for the double add, immediate mask for the flag AND.
*/
`timescale 1ns/1ns
module asa_alu (
    // Operation and operands
    input asa_pkg::asa_op_t op,
    input logic [7:0] acc_a,
    input logic [7:0] acc_b,
    input asa_pkg::asa_flags_t flags_in,
    input logic [15:0] operand,
    // Results
    output asa_pkg::asa_flags_t flags_out,
    output logic [7:0] res_a,
    output logic [7:0] res_b,
    output logic [7:0] res_mem
);

    // Carry out of a bit from operand and result bits
    function automatic logic carry_of(input logic a, input logic m,
                                      input logic r);
        carry_of = (a & m) | (m & ~r) | (~r & a);
    endfunction

    // Two's complement overflow from sign bits
    function automatic logic ovf_of(input logic a, input logic m,
                                    input logic r);
        ovf_of = (a & m & ~r) | (~a & ~m & r);
    endfunction

    logic [7:0] sum8;
    logic [15:0] sum16;
    logic [7:0] and8;
    logic [7:0] shl8;

    assign sum8 = acc_b + operand[7:0]; // RULE1
    assign sum16 = {acc_a, acc_b} + operand; // RULE6 RULE7
    assign and8 = ((op == asa_pkg::OP_AND_FIRST) ? acc_a : acc_b)
                  & operand[7:0];
    assign shl8 = {operand[6:0], 1'b0}; // RULE13

    // Untouched flags fall through from the defaults
    always_comb begin
        flags_out = flags_in; // RULE19
        res_a = acc_a;
        res_b = acc_b;
        res_mem = operand[7:0];
        case (op)
            asa_pkg::OP_ADD_SECOND: begin
                res_b = sum8; // RULE1
                flags_out.h = carry_of(acc_b[3], operand[3], sum8[3]); // RULE2
                flags_out.n = sum8[7]; // RULE3
                flags_out.z = (sum8 == asa_pkg::ZERO8); // RULE3
                flags_out.v = ovf_of(acc_b[7], operand[7], sum8[7]); // RULE4
                flags_out.c = carry_of(acc_b[7], operand[7], sum8[7]); // RULE5
            end
            asa_pkg::OP_ADD_DOUBLE: begin
                res_a = sum16[15:8]; // RULE7
                res_b = sum16[7:0]; // RULE7
                flags_out.n = sum16[15]; // RULE8
                flags_out.z = (sum16 == asa_pkg::ZERO16); // RULE8
                flags_out.v = ovf_of(acc_a[7], operand[15], sum16[15]); // RULE8
                flags_out.c = carry_of(acc_a[7], operand[15], sum16[15]); // RULE8
            end
            asa_pkg::OP_AND_FIRST, asa_pkg::OP_AND_SECOND: begin
                if (op == asa_pkg::OP_AND_FIRST) begin
                    res_a = and8; // RULE9
                end else begin
                    res_b = and8; // RULE9
                end
                flags_out.n = and8[7]; // RULE3
                flags_out.z = (and8 == asa_pkg::ZERO8); // RULE3
                flags_out.v = 1'b0; // RULE9
            end
            asa_pkg::OP_AND_FLAGS: begin
                flags_out = flags_in & operand[7:0]; // RULE10
            end
            asa_pkg::OP_SHIFT_MEM: begin
                res_mem = shl8; // RULE13
                flags_out.c = operand[7]; // RULE13
                flags_out.n = shl8[7]; // RULE3
                flags_out.z = (shl8 == asa_pkg::ZERO8); // RULE3
                flags_out.v = shl8[7] ^ operand[7]; // RULE14
            end
            default: ;
        endcase
    end

endmodule

// File: src/asa_core.sv
/*
 Execution datapath for the add, AND and shift instruction group with
 an APB register file, a small operand memory and an interrupt gate.
 Assumes software loads operand bytes through the memory window, then
 writes one command word; addressed modes carry a computed address.
*/
// The implementer's own choices: register access over APB and the placing of the registers.
// Notes on behaviour
// RULE1: second accumulator plus byte, no carry
// RULE2: half carry out of bit three
// RULE3: N is result MSB, Z on zero
// RULE4: overflow when like signs change sign
// RULE5: carry out of the sum MSB
// RULE6: double add reads address, then address+1
// RULE7: first accumulator high, second low
// RULE8: double add flags on bit fifteen
// RULE9: AND clears overflow, keeps carries
// RULE10: flag AND keeps bits where mask set
// RULE11: interrupts wait one cycle after clear
// RULE12: clear mask equals flag AND EF
// RULE13: shift left, zero in, carry old bit7
// RULE14: shift overflow is N xor C
// RULE15: add second opcodes CB DB FB EB
// RULE16: double add opcodes C3 D3 F3 E3
// RULE17: AND opcodes 84 94 B4 A4, C4 D4 F4 E4
// RULE18: shift opcodes 78, 68, write back
// RULE19: unaffected flags keep their values
`timescale 1ns/1ns
module asa_core #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // APB slave
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt gate toward the core
    output logic irq_allowed
);

    // Opcode to operation and addressing mode
    function automatic asa_pkg::asa_decode_t decode(input logic [7:0] opc);
        decode.valid = 1'b1;
        decode.op = asa_pkg::OP_NONE;
        decode.mode = asa_pkg::MODE_I;
        case (opc)
            asa_pkg::OPC_ADS_I: decode.op = asa_pkg::OP_ADD_SECOND; // RULE15
            asa_pkg::OPC_ADS_D: begin
                decode.op = asa_pkg::OP_ADD_SECOND; // RULE15
                decode.mode = asa_pkg::MODE_D;
            end
            asa_pkg::OPC_ADS_E: begin
                decode.op = asa_pkg::OP_ADD_SECOND; // RULE15
                decode.mode = asa_pkg::MODE_E;
            end
            asa_pkg::OPC_ADS_X: begin
                decode.op = asa_pkg::OP_ADD_SECOND; // RULE15
                decode.mode = asa_pkg::MODE_X;
            end
            asa_pkg::OPC_ADW_I: decode.op = asa_pkg::OP_ADD_DOUBLE; // RULE16
            asa_pkg::OPC_ADW_D: begin
                decode.op = asa_pkg::OP_ADD_DOUBLE; // RULE16
                decode.mode = asa_pkg::MODE_D;
            end
            asa_pkg::OPC_ADW_E: begin
                decode.op = asa_pkg::OP_ADD_DOUBLE; // RULE16
                decode.mode = asa_pkg::MODE_E;
            end
            asa_pkg::OPC_ADW_X: begin
                decode.op = asa_pkg::OP_ADD_DOUBLE; // RULE16
                decode.mode = asa_pkg::MODE_X;
            end
            asa_pkg::OPC_ANF_I: decode.op = asa_pkg::OP_AND_FIRST; // RULE17
            asa_pkg::OPC_ANF_D: begin
                decode.op = asa_pkg::OP_AND_FIRST; // RULE17
                decode.mode = asa_pkg::MODE_D;
            end
            asa_pkg::OPC_ANF_E: begin
                decode.op = asa_pkg::OP_AND_FIRST; // RULE17
                decode.mode = asa_pkg::MODE_E;
            end
            asa_pkg::OPC_ANF_X: begin
                decode.op = asa_pkg::OP_AND_FIRST; // RULE17
                decode.mode = asa_pkg::MODE_X;
            end
            asa_pkg::OPC_ANS_I: decode.op = asa_pkg::OP_AND_SECOND; // RULE17
            asa_pkg::OPC_ANS_D: begin
                decode.op = asa_pkg::OP_AND_SECOND; // RULE17
                decode.mode = asa_pkg::MODE_D;
            end
            asa_pkg::OPC_ANS_E: begin
                decode.op = asa_pkg::OP_AND_SECOND; // RULE17
                decode.mode = asa_pkg::MODE_E;
            end
            asa_pkg::OPC_ANS_X: begin
                decode.op = asa_pkg::OP_AND_SECOND; // RULE17
                decode.mode = asa_pkg::MODE_X;
            end
            asa_pkg::OPC_ANC_I: decode.op = asa_pkg::OP_AND_FLAGS; // RULE10
            asa_pkg::OPC_SHL_E: begin
                decode.op = asa_pkg::OP_SHIFT_MEM; // RULE18
                decode.mode = asa_pkg::MODE_E;
            end
            asa_pkg::OPC_SHL_X: begin
                decode.op = asa_pkg::OP_SHIFT_MEM; // RULE18
                decode.mode = asa_pkg::MODE_X;
            end
            default: decode.valid = 1'b0;
        endcase
    endfunction

    asa_pkg::asa_state_t st;
    asa_pkg::asa_state_t next_st;
    asa_pkg::asa_decode_t dec;
    asa_pkg::asa_flags_t alu_flags;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic [7:0] alu_mem;
    logic [15:0] alu_opnd;
    logic [15:0] eff_addr;
    logic mem_en;
    logic mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic access;
    logic busy;
    logic unmask_req;

    // Direct mode reaches the zero page; other modes carry a full address
    assign eff_addr = (st.mode == asa_pkg::MODE_D) ?
                      {asa_pkg::DIRECT_PAGE, st.operand[7:0]} : st.operand;
    // Immediate forms take the operand word itself
    assign alu_opnd = (st.mode == asa_pkg::MODE_I) ? st.operand
                                                     : st.mem_opnd;
    assign access = psel && penable && !st.pready;
    assign busy = (st.fsm != asa_pkg::ST_IDLE);
    assign unmask_req = pwdata[asa_pkg::CMD_UNMASK_BIT];
    assign dec = decode(pwdata[asa_pkg::CMD_OPC_LSB +: 8]);

    asa_alu u_alu (
        .op(st.op),
        .acc_a(st.acc_a),
        .acc_b(st.acc_b),
        .flags_in(st.flags),
        .operand(alu_opnd),
        .flags_out(alu_flags),
        .res_a(alu_a),
        .res_b(alu_b),
        .res_mem(alu_mem)
    );

    asa_mem #(
        .ADDR_W(ADDR_W)
    ) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .en(mem_en),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // Sequencer, register file and APB answer in one next-state process
    always_comb begin
        next_st = st;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.irq_hold = 1'b0;
        mem_en = 1'b0;
        mem_we = 1'b0;
        mem_addr = st.sw_addr[ADDR_W-1:0];
        mem_wdata = pwdata[7:0];

        // A clear of the mask by the flag AND holds the gate shut one more cycle
        next_st.irq_allowed = !st.flags.i && !st.irq_hold; // RULE11

        case (st.fsm)
            asa_pkg::ST_IDLE: begin
            end
            asa_pkg::ST_READ: begin
                mem_en = 1'b1;
                mem_addr = eff_addr[ADDR_W-1:0];
                next_st.fsm = asa_pkg::ST_GET_HI;
            end
            asa_pkg::ST_GET_HI: begin
                if (st.op == asa_pkg::OP_ADD_DOUBLE) begin
                    // High byte first, then the byte after it
                    next_st.mem_opnd[15:8] = mem_rdata; // RULE6
                    mem_en = 1'b1;
                    mem_addr = ADDR_W'(eff_addr + 16'h0001); // RULE6
                    next_st.fsm = asa_pkg::ST_GET_LO;
                end else begin
                    next_st.mem_opnd = {8'h00, mem_rdata};
                    next_st.fsm = asa_pkg::ST_EXEC;
                end
            end
            asa_pkg::ST_GET_LO: begin
                next_st.mem_opnd[7:0] = mem_rdata; // RULE6
                next_st.fsm = asa_pkg::ST_EXEC;
            end
            asa_pkg::ST_EXEC: begin
                next_st.acc_a = alu_a;
                next_st.acc_b = alu_b;
                next_st.flags = alu_flags;
                if (st.op == asa_pkg::OP_AND_FLAGS && st.flags.i &&
                    !alu_flags.i) begin
                    next_st.irq_hold = 1'b1; // RULE11
                    next_st.irq_allowed = 1'b0; // RULE11
                end
                if (st.op == asa_pkg::OP_SHIFT_MEM) begin
                    // Write back to the location just read
                    mem_en = 1'b1; // RULE18
                    mem_we = 1'b1;
                    mem_addr = eff_addr[ADDR_W-1:0]; // RULE18
                    mem_wdata = alu_mem; // RULE13
                end
                next_st.fsm = asa_pkg::ST_IDLE;
            end
            default: begin
                next_st.fsm = asa_pkg::ST_IDLE;
            end
        endcase

        // APB access phase; the memory window waits while busy
        if (access) begin
            next_st.pready = 1'b1;
            next_st.prdata = 32'h0000_0000;
            case (paddr)
                asa_pkg::OFS_ACC_FIRST: begin
                    next_st.prdata = {24'h000000, st.acc_a};
                    if (pwrite && busy) begin
                        next_st.pslverr = 1'b1;
                    end else if (pwrite) begin
                        next_st.acc_a = pwdata[7:0];
                    end
                end
                asa_pkg::OFS_ACC_SECOND: begin
                    next_st.prdata = {24'h000000, st.acc_b};
                    if (pwrite && busy) begin
                        next_st.pslverr = 1'b1;
                    end else if (pwrite) begin
                        next_st.acc_b = pwdata[7:0];
                    end
                end
                asa_pkg::OFS_FLAGS: begin
                    next_st.prdata = {24'h000000, st.flags};
                    if (pwrite && busy) begin
                        next_st.pslverr = 1'b1;
                    end else if (pwrite) begin
                        next_st.flags = pwdata[7:0];
                    end
                end
                asa_pkg::OFS_COMMAND: begin
                    next_st.prdata = st.cmd_last;
                    if (pwrite && busy) begin
                        next_st.pslverr = 1'b1;
                    end else if (pwrite && unmask_req) begin
                        // Same path as the flag AND with a fixed mask
                        next_st.cmd_last = pwdata;
                        next_st.bad_opcode = 1'b0;
                        next_st.op = asa_pkg::OP_AND_FLAGS; // RULE12
                        next_st.mode = asa_pkg::MODE_I;
                        next_st.operand = {8'h00, asa_pkg::UNMASK_AND}; // RULE12
                        next_st.fsm = asa_pkg::ST_EXEC;
                    end else if (pwrite) begin
                        next_st.cmd_last = pwdata;
                        next_st.bad_opcode = !dec.valid;
                        next_st.op = dec.op;
                        next_st.mode = dec.mode;
                        next_st.operand = pwdata[asa_pkg::CMD_OPR_LSB +: 16];
                        if (!dec.valid) begin
                            next_st.fsm = asa_pkg::ST_IDLE;
                        end else if (dec.mode == asa_pkg::MODE_I) begin
                            next_st.fsm = asa_pkg::ST_EXEC;
                        end else begin
                            next_st.fsm = asa_pkg::ST_READ;
                        end
                    end
                end
                asa_pkg::OFS_STATUS: begin
                    next_st.prdata[asa_pkg::STA_BUSY_BIT] = busy;
                    next_st.prdata[asa_pkg::STA_BAD_BIT] = st.bad_opcode;
                    next_st.prdata[asa_pkg::STA_IRQ_BIT] = st.irq_allowed;
                end
                asa_pkg::OFS_MEM_ADDR: begin
                    next_st.prdata = {16'h0000, st.sw_addr};
                    if (pwrite) begin
                        next_st.sw_addr = pwdata[15:0];
                    end
                end
                asa_pkg::OFS_MEM_DATA: begin
                    if (busy) begin
                        next_st.pready = 1'b0;
                    end else if (pwrite) begin
                        mem_en = 1'b1;
                        mem_we = 1'b1;
                    end else if (!st.mem_pend) begin
                        // Registered memory read costs an extra cycle
                        mem_en = 1'b1;
                        next_st.mem_pend = 1'b1;
                        next_st.pready = 1'b0;
                    end else begin
                        next_st.mem_pend = 1'b0;
                        next_st.prdata = {24'h000000, mem_rdata};
                    end
                end
                default: begin
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
    end

    // All state of the block except the operand memory in one register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.fsm <= asa_pkg::ST_IDLE;
            st.acc_a <= asa_pkg::ACC_RESET;
            st.acc_b <= asa_pkg::ACC_RESET;
            st.flags <= asa_pkg::FLAGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign irq_allowed = st.irq_allowed;

endmodule

// File: testbench/asa_core_assertions.sv
/*
 Checker on the bus port and interrupt gate of asa_core.
 Assumes a master that holds each request until pready.
*/
`timescale 1ns/1ns
module asa_core_chk (
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // Bus and gate
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic irq_allowed
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Answer phase, and addresses outside the map
    wire done = psel && penable && pready;
    wire bad_a = paddr > 8'h18 || paddr[1:0] != 2'h0;
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_ready_req: assert property (pready |-> psel && penable)
        else $error("pready without a request");
    a_answer_bound: assert property (psel && penable && !pready
        |-> ##[1:20] pready) else $error("no answer");
    a_bad_err: assert property (done && bad_a |-> pslverr)
        else $error("unmapped access accepted");
    a_bad_zero: assert property (done && bad_a && !pwrite
        |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_read_ok: assert property (done && !bad_a && !pwrite |-> !pslverr)
        else $error("mapped read refused");
    a_flags_irq: assert property (done && pwrite && paddr == 8'h08
        && pwdata[4] && !pslverr |-> ##[1:3] !irq_allowed)
        else $error("mask set but gate open");
    a_cli_delay: assert property (done && pwrite && paddr == 8'h0c
        && pwdata[24] && !pslverr && !irq_allowed
        |-> ##1 !irq_allowed[*2] ##1 irq_allowed)
        else $error("gate opened at wrong cycle");
endmodule
bind asa_core asa_core_chk asa_core_chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_allowed(irq_allowed));

// File: testbench/asa_apb_host.sv
/*
 Software side of the block: an APB master issuing one transfer.
 Assumes the caller serialises transfers.
*/
`timescale 1ns/1ns
module asa_apb_host (
    // Clock
    input wire logic pclk,
    // Master outputs
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // Slave answer
    input wire logic pready
);
    // Idle bus from time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // Request held until pready is seen high at an edge
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
endmodule

// File: testbench/tb.sv
/*
 Random runs of every opcode against a reference model.
 Assumes commands finish within six cycles of their answer.
*/
`timescale 1ns/1ns
module tb;
    logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr;
    logic irq_allowed;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rs = 32'h47880e44, q[$];
    int err_total = 0, n_checks = 0, cyc = 0;
    logic [7:0] ops[20] = '{8'hcb, 8'hdb, 8'hfb, 8'heb, 8'hc3, 8'hd3,
        8'hf3, 8'he3, 8'h84, 8'h94, 8'hb4, 8'ha4, 8'hc4, 8'hd4, 8'hf4,
        8'he4, 8'h10, 8'h78, 8'h68, 8'h00};
    asa_core asa_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_allowed(irq_allowed));
    asa_apb_host asa_apb_host_i (.pclk(pclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready));
    always #4 pclk = ~pclk;
    task automatic rd(logic [7:0] a, logic [31:0] e);
        q.push_back(e);
        asa_apb_host_i.xfer(1'b0, a, 32'h0);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        asa_apb_host_i.xfer(1'b1, a, {24'h0, d});
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", err_total, n_checks);
        if (err_total == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Read watcher: oldest note against each answer; also the hang limit
    always @(posedge pclk) begin
        logic [31:0] e;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            end_sim;
        end
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = q.pop_front();
            n_checks++;
            if (prdata !== e) begin
                err_total++;
                $display("unexpected %0t %h %h", $time, prdata, e);
            end
        end
    end
    initial begin
        logic [7:0] a, b, f, hi, lo, ad, op, m8, r, ea, eb, ef, em;
        logic [16:0] t;
        logic im;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h08, 32'hd0);
        rd(8'h1c, 32'h0);
        rd(8'h02, 32'h0);
        for (int k = 0; k < 60; k++) begin
            op = ops[k % 20];
            rs = lfsr(rs);
            {a, b, f, hi} = rs;
            rs = lfsr(rs);
            {lo, ad} = rs[15:0];
            f[4] = f[4] | (op == 8'h00);
            im = op[7:4] == 4'h8 || op[7:4] == 4'hc || op == 8'h10;
            m8 = im ? lo : hi;
            wr(8'h00, a);
            wr(8'h04, b);
            wr(8'h08, f);
            wr(8'h14, ad + 8'h01);
            wr(8'h18, lo);
            wr(8'h14, ad);
            wr(8'h18, hi);
            asa_apb_host_i.xfer(1'b1, 8'h0c, op == 8'h00 ? 32'h01000000 :
                {8'h00, im ? {hi, lo} : {8'h00, ad}, op});
            repeat (6) @(posedge pclk);
            {ea, eb, ef, em} = {a, b, f, hi};
            case (op[3:0])
                4'hb: begin
                    t = {9'h0, b} + {9'h0, m8};
                    eb = t[7:0];
                    ef[5] = b[4] ^ m8[4] ^ eb[4];
                    ef[3:0] = {eb[7], eb == 0, b[7] == m8[7] && eb[7] != b[7], t[8]};
                end
                4'h3: begin
                    t = {1'b0, a, b} + {1'b0, hi, lo};
                    {ea, eb} = t[15:0];
                    ef[3:0] = {t[15], t[15:0] == 0, a[7] == hi[7] && t[15] != a[7], t[16]};
                end
                4'h4: begin
                    r = m8 & (op[6] ? b : a);
                    if (op[6]) eb = r;
                    else ea = r;
                    ef[3:1] = {r[7], r == 0, 1'b0};
                end
                4'h0: ef = f & (op == 8'h10 ? lo : 8'hef);
                default: begin
                    em = {hi[6:0], 1'b0};
                    ef[3:0] = {em[7], em == 0, em[7] ^ hi[7], hi[7]};
                end
            endcase
            rd(8'h00, {24'h0, ea});
            rd(8'h04, {24'h0, eb});
            rd(8'h08, {24'h0, ef});
            rd(8'h18, {24'h0, em});
        end
        end_sim;
    end
    // Source of random operands and accumulators
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
endmodule
